// [rtl/mtm_regs.vh]
// Register indices, reset values, limits and timing for the terminal mapper
`ifndef MTM_REGS_VH
`define MTM_REGS_VH
// Register indices; byte address is four times the index
`define MTM_REG_IN_FUNC 5'h00
`define MTM_REG_OUT_FUNC 5'h04
`define MTM_REG_FORCE 5'h08
`define MTM_REG_VI_SEL 5'h0D
`define MTM_REG_VI_WORD 5'h0E
`define MTM_REG_VO_CTL 5'h0F
`define MTM_REG_VO_WORD 5'h10
`define MTM_REG_VI_FUNC 5'h11
`define MTM_REG_DIR_POL 5'h19
`define MTM_REG_Z_WIDTH 5'h1A
`define MTM_REG_SER_SEL 5'h1B
`define MTM_REG_VI6_ALT 5'h1C
`define MTM_REG_STATUS 5'h1D
`define MTM_REG_COUNT 29
// Status word field positions
`define MTM_ST_PIN_LSB 0
`define MTM_ST_DIRPOS 4
`define MTM_ST_ZPULSE 5
`define MTM_ST_OUT_LSB 8
// Reset values
`define MTM_RST_IN1_FUNC 8'h01
`define MTM_RST_IN2_FUNC 8'h02
`define MTM_RST_IN3_FUNC 8'h03
`define MTM_RST_IN4_FUNC 8'h04
`define MTM_RST_OUT1_FUNC 8'h02
`define MTM_RST_OUT2_FUNC 8'h03
`define MTM_RST_OUT3_FUNC 8'h05
`define MTM_RST_OUT4_FUNC 8'h08
`define MTM_RST_FORCE 8'h00
`define MTM_RST_VI_SEL 8'h00
`define MTM_RST_VI_WORD 8'h00
`define MTM_RST_VO_CTL 8'h00
`define MTM_RST_VO_WORD 8'h00
`define MTM_RST_VI1_FUNC 8'h05
`define MTM_RST_VI2_FUNC 8'h06
`define MTM_RST_VI3_FUNC 8'h07
`define MTM_RST_VI4_FUNC 8'h08
`define MTM_RST_VI5_FUNC 8'h09
`define MTM_RST_VI6_FUNC 8'h0A
`define MTM_RST_VI7_FUNC 8'h0B
`define MTM_RST_VI8_FUNC 8'h0C
`define MTM_RST_VI6_ALT 8'h0B
`define MTM_RST_DIR_POL 8'h00
`define MTM_RST_Z_WIDTH 8'h32
`define MTM_RST_SER_SEL 8'h00
// Accepted value ranges
`define MTM_MAX_CODE 8'h63
`define MTM_MAX_BYTE 8'hFF
`define MTM_MAX_FLAG 8'h01
`define MTM_MAX_VI_SEL 8'h02
`define MTM_MAX_VO_WORD 8'h0F
`define MTM_MAX_Z_WIDTH 8'hC8
`define MTM_MIN_Z_WIDTH 8'h01
// Virtual input selector modes
`define MTM_VI_PHYS 2'h0
`define MTM_VI_VIRT 2'h1
`define MTM_VI_BOTH 2'h2
// Timing: clock period and index pulse width unit
`define MTM_CLK_NS 8
`define MTM_Z_UNIT_NS 1000
// Bus responses
`define MTM_RESP_OKAY 2'h0
`define MTM_RESP_SLVERR 2'h2
`endif

// [rtl/mtm_terminal_mapper.v]
// Multifunction terminal mapper with AXI4-Lite register slave
`timescale 1ns/1ns
`include "mtm_regs.vh"
module mtm_terminal_mapper (
   input wire clock,
   input wire rst,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [3:0] inTermN,
   input wire cmdDirIn,
   input wire indexEvent,
   input wire [99:0] driveFunc,
   output reg [99:0] funcActive,
   output reg [3:0] outTermN,
   output reg dirPositive,
   output reg indexPulse,
   output reg rs485En,
   output reg diffOut
);

   // Clock cycles per width unit, rounded up so a unit never runs short
   localparam integer ZUNIT =
      (`MTM_Z_UNIT_NS + `MTM_CLK_NS - 1) / `MTM_CLK_NS;
   localparam [6:0] ZUNIT_LAST = ZUNIT[6:0] - 7'h01;

   // Reset value of each register index
   function [7:0] resetVal;
      input [4:0] i;
      begin
         case (i)
            5'h00: resetVal = `MTM_RST_IN1_FUNC;
            5'h01: resetVal = `MTM_RST_IN2_FUNC;
            5'h02: resetVal = `MTM_RST_IN3_FUNC;
            5'h03: resetVal = `MTM_RST_IN4_FUNC;
            5'h04: resetVal = `MTM_RST_OUT1_FUNC;
            5'h05: resetVal = `MTM_RST_OUT2_FUNC;
            5'h06: resetVal = `MTM_RST_OUT3_FUNC;
            5'h07: resetVal = `MTM_RST_OUT4_FUNC;
            `MTM_REG_VI_SEL: resetVal = `MTM_RST_VI_SEL;
            `MTM_REG_VI_WORD: resetVal = `MTM_RST_VI_WORD;
            `MTM_REG_VO_CTL: resetVal = `MTM_RST_VO_CTL;
            `MTM_REG_VO_WORD: resetVal = `MTM_RST_VO_WORD;
            5'h11: resetVal = `MTM_RST_VI1_FUNC;
            5'h12: resetVal = `MTM_RST_VI2_FUNC;
            5'h13: resetVal = `MTM_RST_VI3_FUNC;
            5'h14: resetVal = `MTM_RST_VI4_FUNC;
            5'h15: resetVal = `MTM_RST_VI5_FUNC;
            5'h16: resetVal = `MTM_RST_VI6_FUNC;
            5'h17: resetVal = `MTM_RST_VI7_FUNC;
            5'h18: resetVal = `MTM_RST_VI8_FUNC;
            `MTM_REG_DIR_POL: resetVal = `MTM_RST_DIR_POL;
            `MTM_REG_Z_WIDTH: resetVal = `MTM_RST_Z_WIDTH;
            `MTM_REG_SER_SEL: resetVal = `MTM_RST_SER_SEL;
            `MTM_REG_VI6_ALT: resetVal = `MTM_RST_VI6_ALT;
            default: resetVal = `MTM_RST_FORCE;
         endcase
      end
   endfunction

   // Highest value each register accepts
   function [7:0] maxVal;
      input [4:0] i;
      begin
         case (i)
            `MTM_REG_VI_SEL: maxVal = `MTM_MAX_VI_SEL;
            `MTM_REG_VI_WORD: maxVal = `MTM_MAX_BYTE;
            `MTM_REG_VO_CTL: maxVal = `MTM_MAX_FLAG;
            `MTM_REG_VO_WORD: maxVal = `MTM_MAX_VO_WORD;
            `MTM_REG_DIR_POL: maxVal = `MTM_MAX_FLAG;
            `MTM_REG_Z_WIDTH: maxVal = `MTM_MAX_Z_WIDTH;
            `MTM_REG_SER_SEL: maxVal = `MTM_MAX_FLAG;
            5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C: maxVal = `MTM_MAX_BYTE;
            default: maxVal = `MTM_MAX_CODE;
         endcase
      end
   endfunction

   reg [7:0] cfg_r [0:`MTM_REG_COUNT-1];
   reg awHeld_r;
   reg wHeld_r;
   reg [4:0] awIdx_r;
   reg [7:0] wByte_r;
   reg wOk_r;
   reg awHigh_r;
   reg [3:0] pinMeta_r;
   reg [3:0] pinSync_r;
   reg dirMeta_r;
   reg dirSync_r;
   reg [6:0] zPre_r;
   reg [7:0] zLeft_r;
   reg [7:0] zLeft_nxt;
   reg [6:0] zPre_nxt;
   wire [31:0] statusWord;
   wire [11:0] slotAct;
   wire [39:0] forceBits;
   wire [99:0] funcHit;
   wire doWrite;
   wire wrRangeOk;
   wire [4:0] arIdx;
   wire [1:0] viSel;
   integer n;
   integer j;
   wire awTake;
   wire wTake;
   wire arTake;
   wire wrAccept;
   wire physOn;
   wire virtOn;

   assign viSel = cfg_r[`MTM_REG_VI_SEL][1:0];

   // Mode decode shared by every slot of one kind; selector 3 is refused
   assign physOn = (viSel == `MTM_VI_PHYS) |
      (viSel == `MTM_VI_BOTH);
   assign virtOn = (viSel == `MTM_VI_VIRT) |
      (viSel == `MTM_VI_BOTH);

   // Write address and data are caught independently, in either order
   // No new beat is taken while a response waits, so the held address
   // and data always belong to the write being answered
   assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
   assign s_axi_wready = ~wHeld_r & ~s_axi_bvalid;
   assign awTake = s_axi_awvalid & s_axi_awready;
   assign wTake = s_axi_wvalid & s_axi_wready;
   assign doWrite = awHeld_r & wHeld_r & ~s_axi_bvalid;
   assign wrRangeOk = ~awHigh_r & wOk_r &
      (awIdx_r < `MTM_REG_COUNT) &
      (wByte_r <= maxVal(awIdx_r)) &
      ((awIdx_r != `MTM_REG_Z_WIDTH) | (wByte_r >= `MTM_MIN_Z_WIDTH));

   // A write lands only when every check passes; otherwise nothing changes
   assign wrAccept = doWrite & wrRangeOk;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awIdx_r <= 5'h00;
         awHigh_r <= 1'b0;
         wByte_r <= 8'h00;
         wOk_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MTM_RESP_OKAY;
      end else begin
         if (awTake) begin
            awHeld_r <= 1'b1;
            awIdx_r <= s_axi_awaddr[6:2];
            awHigh_r <= |s_axi_awaddr[31:7];
         end
         if (wTake) begin
            wHeld_r <= 1'b1;
            wByte_r <= s_axi_wdata[7:0];
            // Upper bits must be zero and the low lane enabled
            wOk_r <= s_axi_wstrb[0] & ~|s_axi_wdata[31:8];
         end
         // Response: OKAY when the value was stored, SLVERR when refused
         if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrRangeOk ? `MTM_RESP_OKAY : `MTM_RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register file; out-of-range values are refused and the old one kept
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         for (n = 0; n < `MTM_REG_COUNT; n = n + 1) begin
            cfg_r[n] <= resetVal(n[4:0]);
         end
      end else if (wrAccept) begin
         cfg_r[awIdx_r] <= wByte_r;
      end
   end

   // Read channel: one answer per address, one cycle after acceptance
   // Unmapped and high addresses answer SLVERR with zero data
   assign s_axi_arready = ~s_axi_rvalid;
   assign arTake = s_axi_arvalid & s_axi_arready;
   assign arIdx = s_axi_araddr[6:2];

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `MTM_RESP_OKAY;
      end else if (arTake) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `MTM_RESP_OKAY;
         if (|s_axi_araddr[31:7]) begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MTM_RESP_SLVERR;
         end else if (arIdx < `MTM_REG_COUNT) begin
            s_axi_rdata <= {24'h000000, cfg_r[arIdx]};
         end else if (arIdx == `MTM_REG_STATUS) begin
            s_axi_rdata <= statusWord;
         end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MTM_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Two-flop synchronisers for the pins; the first stage feeds only the second
   // Pins reset to the released level, so no false assertion follows reset
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         pinMeta_r <= 4'hF;
         pinSync_r <= 4'hF;
         dirMeta_r <= 1'b0;
         dirSync_r <= 1'b0;
      end else begin
         pinMeta_r <= inTermN;
         pinSync_r <= pinMeta_r;
         dirMeta_r <= cmdDirIn;
         dirSync_r <= dirMeta_r;
      end
   end

   // Read-only status: asserted pins, direction, index pulse, terminals
   assign statusWord = {20'h00000, outTermN,
      2'h0, indexPulse,
      dirPositive, ~pinSync_r};

   // Force words gathered into one vector; bit j forces function j+1
   // Limitation: five words reach codes 1..40 only; higher codes cannot
   genvar g;
   genvar k;
   generate
      for (g = 0; g < 5; g = g + 1) begin : forceGrp
         assign forceBits[g*8+7:g*8] = cfg_r[`MTM_REG_FORCE+g];
      end
   endgenerate

   // Logical input slots: 0..3 physical, 4..11 virtual word bits
   // All twelve slots always exist; the mode only gates which ones count
   wire [6:0] slotCode [0:11];
   generate
      for (g = 0; g < 12; g = g + 1) begin : slotGrp
         if (g < 4) begin : physSlot
            // Low pin level means asserted; used in modes 0 and 2
            assign slotAct[g] = ~pinSync_r[g] &
               physOn;
            assign slotCode[g] = cfg_r[`MTM_REG_IN_FUNC+g][6:0];
         end else begin : virtSlot
            assign slotAct[g] = cfg_r[`MTM_REG_VI_WORD][g-4] &
               virtOn;
            assign slotCode[g] = cfg_r[`MTM_REG_VI_FUNC+g-4][6:0];
         end
      end
   endgenerate

   // One matcher per function code; code 0 never matches anything
   // Several slots may share a code; any one of them raises the function
   generate
      for (k = 0; k < 100; k = k + 1) begin : funcGrp
         wire [11:0] match;
         for (g = 0; g < 12; g = g + 1) begin : slotMatch
            assign match[g] = ({25'h0000000, slotCode[g]} == k);
         end
         if (k == 0) begin : nullCode
            assign funcHit[k] = 1'b0;
         end else if (k <= 40) begin : forcible
            assign funcHit[k] = |(match & slotAct) | forceBits[k-1];
         end else begin : plain
            assign funcHit[k] = |(match & slotAct);
         end
      end
   endgenerate

   // Registered function levels and terminal outputs
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         funcActive <= 100'h0;
         outTermN <= 4'hF;
         dirPositive <= 1'b1;
      end else begin
         funcActive <= funcHit;
         for (j = 0; j < 4; j = j + 1) begin
            // Virtual control hands the terminals to software
            if (cfg_r[`MTM_REG_VO_CTL][0]) begin
               outTermN[j] <= ~cfg_r[`MTM_REG_VO_WORD][j];
            // Code 0 keeps the terminal released instead of reading bit 0
            end else if (cfg_r[`MTM_REG_OUT_FUNC+j] == 8'h00) begin
               outTermN[j] <= 1'b1;
            end else begin
               outTermN[j] <=
                  ~driveFunc[cfg_r[`MTM_REG_OUT_FUNC+j][6:0]];
            end
         end
         // Polarity 1 inverts the direction sense
         dirPositive <= dirSync_r ^ cfg_r[`MTM_REG_DIR_POL][0];
      end
   end

   // Index pulse length counter; a new event restarts the full width
   // Width counts whole units of ZUNIT cycles; a width of 0 is refused
   always @* begin
      zLeft_nxt = zLeft_r;
      zPre_nxt = zPre_r;
      if (indexEvent) begin
         zLeft_nxt = cfg_r[`MTM_REG_Z_WIDTH];
         zPre_nxt = 7'h00;
      end else if (zLeft_r != 8'h00) begin
         if (zPre_r == ZUNIT_LAST) begin
            zPre_nxt = 7'h00;
            zLeft_nxt = zLeft_r - 8'h01;
         end else begin
            zPre_nxt = zPre_r + 7'h01;
         end
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         zLeft_r <= 8'h00;
         zPre_r <= 7'h00;
         indexPulse <= 1'b0;
      end else begin
         zLeft_r <= zLeft_nxt;
         zPre_r <= zPre_nxt;
         indexPulse <= (zLeft_nxt != 8'h00);
      end
   end

   // Serial port use: RS485 or extra differential index output
   // The differential copy lags the index pulse by one cycle
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         rs485En <= 1'b1;
         diffOut <= 1'b0;
      end else begin
         rs485En <= ~cfg_r[`MTM_REG_SER_SEL][0];
         diffOut <= cfg_r[`MTM_REG_SER_SEL][0] & indexPulse;
      end
   end

endmodule

// [tb/mtm_sva.sv]
// Port assertions for the terminal mapper
`timescale 1ns/1ns
module mtm_sva (
   input wire clock,
   input wire rst,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire indexEvent,
   input wire indexPulse,
   input wire rs485En,
   input wire diffOut,
   input wire [99:0] funcActive
);
   int hiCnt_r;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Pulse length; a restart only lengthens it, so a floor is enough
   always @(posedge clock or posedge rst) begin
      if (rst)
         hiCnt_r <= 0;
      else
         hiCnt_r <= indexPulse ? hiCnt_r + 1 : 0;
   end
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped early");
   a_w_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("no write response");
   a_ar_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("no read data");
   a_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready &&
      !s_axi_wready) else $error("write taken while answering");
   a_idx_start: assert property (indexEvent |=> indexPulse)
      else $error("index pulse did not start");
   a_idx_width: assert property ($fell(indexPulse) |-> hiCnt_r >= 125)
      else $error("index pulse too short");
   a_port_excl: assert property (diffOut |-> !rs485En)
      else $error("differential output while serial port in use");
   a_code_idle: assert property (!funcActive[0])
      else $error("function code zero active");
   c_pulse: cover property ($fell(indexPulse));
   c_diff: cover property (diffOut);
   c_top: cover property (funcActive[99]);
endmodule

// [tb/mtm_switch_model.sv]
// Switch bank and direction source wired to the input terminals
`timescale 1ns/1ns
module mtm_switch_model (
   input wire clock,
   input wire [3:0] closed,
   input wire dirLevel,
   output logic [3:0] inTermN = 4'hF,
   output logic cmdDirIn = 1'h0
);
   // Open contacts sit at the pull-up level, closed ones pull low
   always @(posedge clock) begin
      inTermN <= ~closed;
      cmdDirIn <= dirLevel;
   end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the terminal mapper
`timescale 1ns/1ns
module testbench;
   localparam logic [7:0] DEFS [29] = '{8'h01, 8'h02, 8'h03, 8'h04,
      8'h02, 8'h03, 8'h05, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
      8'h0A, 8'h0B, 8'h0C, 8'h00, 8'h32, 8'h00, 8'h0B};
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
   logic [3:0] s_axi_wstrb = 4'h1, closed = 4'h0;
   // Ready lines stay high, so no task raises what another just lowered
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
   logic dirLevel = 1'h0, indexEvent = 1'h0;
   logic [99:0] driveFunc = '0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, cmdDirIn, dirPositive, indexPulse, rs485En, diffOut;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [3:0] inTermN, outTermN;
   wire [99:0] funcActive;
   int n_fail = 0, samples_checked = 0;
   always #4 clock = ~clock;
   mtm_switch_model u_sw (.clock, .closed, .dirLevel, .inTermN, .cmdDirIn);
   mtm_terminal_mapper u_mtm_terminal_mapper (.clock, .rst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .inTermN,
      .cmdDirIn, .indexEvent, .driveFunc, .funcActive, .outTermN,
      .dirPositive, .indexPulse, .rs485En, .diffOut);
   task chk(input logic [99:0] seen, input logic [99:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         n_fail++;
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task hang;
      n_fail++;
      end_sim;
   endtask
   // Handshakes are judged at the falling edge, where nothing moves
   task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
      int k;
      logic ta, tw, tb;
      logic [1:0] rb;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      for (k = 0; k < 60; k++) begin
         @(negedge clock);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         rb = s_axi_bresp;
         @(posedge clock);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         if (tb) break;
      end
      if (k == 60) hang;
      chk(rb, er);
   endtask
   task automatic rd(input logic [31:0] a, d, input logic [1:0] er);
      int k;
      logic ta, tr;
      logic [31:0] rv;
      logic [1:0] rr;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      for (k = 0; k < 60; k++) begin
         @(negedge clock);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         rv = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge clock);
         if (ta) s_axi_arvalid <= 1'h0;
         if (tr) break;
      end
      if (k == 60) hang;
      chk(rv, d);
      chk(rr, er);
   endtask
   // Pin synchroniser plus mapping needs three edges; five leaves margin
   task settle;
      repeat (5) @(posedge clock);
   endtask
   task t_defaults;
      for (int i = 0; i < 29; i++) rd(4 * i, DEFS[i], 2'h0);
      rd(32'h78, 32'h0, 2'h2);
   endtask
   // Out-of-range values and status writes must be refused and leave the register alone
   task t_refuse;
      wr(32'h0, 32'h64, 2'h2);
      rd(32'h0, 32'h1, 2'h0);
      wr(32'h68, 32'h0, 2'h2);
      wr(32'h68, 32'hC9, 2'h2);
      wr(32'h34, 32'h3, 2'h2);
      wr(32'h40, 32'h10, 2'h2);
      wr(32'h74, 32'h0, 2'h2);
   endtask
   task t_phys;
      closed <= 4'h1;
      settle;
      chk(funcActive, 100'h2);
      wr(32'hC, 32'h63, 2'h0);
      wr(32'h0, 32'h0, 2'h0);
      closed <= 4'h9;
      settle;
      chk(funcActive, 100'h1 << 99);
      rd(32'h74, 32'hF09, 2'h0);
      closed <= 4'h0;
      wr(32'h0, 32'h1, 2'h0);
      wr(32'hC, 32'h4, 2'h0);
   endtask
   task t_virt;
      wr(32'h34, 32'h1, 2'h0);
      wr(32'h38, 32'h81, 2'h0);
      closed <= 4'h1;
      settle;
      chk(funcActive, (100'h1 << 5) | (100'h1 << 12));
      wr(32'h34, 32'h2, 2'h0);
      settle;
      chk(funcActive, (100'h1 << 5) | (100'h1 << 12) | 100'h2);
      wr(32'h34, 32'h0, 2'h0);
      closed <= 4'h0;
      wr(32'h20, 32'h1, 2'h0);
      wr(32'h30, 32'h80, 2'h0);
      settle;
      chk(funcActive, (100'h1 << 40) | 100'h2);
      wr(32'h20, 32'h0, 2'h0);
      wr(32'h30, 32'h0, 2'h0);
   endtask
   task t_dir;
      dirLevel <= 1'h1;
      settle;
      chk(dirPositive, 1'h1);
      wr(32'h64, 32'h1, 2'h0);
      settle;
      chk(dirPositive, 1'h0);
      dirLevel <= 1'h0;
      settle;
      chk(dirPositive, 1'h1);
      wr(32'h64, 32'h0, 2'h0);
   endtask
   task t_out;
      for (int k = 0; k < 4; k++) begin
         driveFunc <= 100'h1 << DEFS[4 + k];
         settle;
         chk(outTermN, 4'(~(4'h1 << k)));
      end
      driveFunc <= '0;
      wr(32'h3C, 32'h1, 2'h0);
      wr(32'h40, 32'hA, 2'h0);
      settle;
      chk(outTermN, 4'h5);
      wr(32'h3C, 32'h0, 2'h0);
   endtask
   // Counts high cycles of the index pulse and the differential copy
   task automatic pulse(output int n, m);
      n = 0;
      m = 0;
      indexEvent <= 1'h1;
      @(posedge clock);
      indexEvent <= 1'h0;
      for (int k = 0; k < 6400; k++) begin
         @(negedge clock);
         n += indexPulse;
         m += diffOut;
         @(posedge clock);
      end
   endtask
   task t_index;
      int n, m;
      pulse(n, m);
      chk(n, 6250);
      chk(m, 0);
      wr(32'h68, 32'h1, 2'h0);
      wr(32'h6C, 32'h1, 2'h0);
      settle;
      chk(rs485En, 1'h0);
      pulse(n, m);
      chk(n, 125);
      chk(m, 125);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'h0;
      @(posedge clock);
      t_defaults;
      t_refuse;
      t_phys;
      t_virt;
      t_dir;
      t_out;
      t_index;
      end_sim;
   end
endmodule
bind mtm_terminal_mapper mtm_sva u_sva (.clock, .rst, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .indexEvent, .indexPulse, .rs485En, .diffOut,
   .funcActive);
